// ---- flm_pkg.sv ----
package flm_pkg;
  // Clock and derived timing
  localparam int CLK_NS = 25;
  localparam int US_NS = 1000;
  localparam int US_CYC = US_NS / CLK_NS;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC_DEF = MS_NS / CLK_NS;
  localparam int PWM_SLOT_NS = 2000;
  localparam int PWM_SLOT_CYC = PWM_SLOT_NS / CLK_NS;
  localparam int IND_STEP_LOG2 = 3;
  localparam logic [11:0] BLINK_ON_UNIT_MS = 12'h080;
  localparam logic [11:0] BLINK_PER_UNIT_MS = 12'h400;

  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_LED = 12'h004;
  localparam logic [11:0] ADDR_FLASH = 12'h008;
  localparam logic [11:0] ADDR_IND = 12'h00C;
  localparam logic [11:0] ADDR_BOOST = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  localparam logic [11:0] ADDR_STATE = 12'h018;

  // Register widths and field positions
  localparam int CTRL_W = 11;
  localparam int C_MODE = 0;
  localparam int C_TEN = 3;
  localparam int C_TTYPE = 4;
  localparam int C_TXM = 5;
  localparam int C_HOLD = 7;
  localparam int C_POST = 8;
  localparam int LED_W = 24;
  localparam int L_CUR = 0;
  localparam int L_RNG = 17;
  localparam int L_DUTY = 19;
  localparam int FL_W = 16;
  localparam int F_DUR = 0;
  localparam int F_TMO = 8;
  localparam int IND_W = 11;
  localparam int I_ON = 0;
  localparam int I_PER = 1;
  localparam int I_ONT = 3;
  localparam int I_RISE = 5;
  localparam int I_FALL = 6;
  localparam int I_LVL = 7;
  localparam int BST_W = 6;
  localparam int B_PEAK = 0;
  localparam int B_RED = 3;
  localparam int S_DRV = 0;
  localparam int S_EN = 17;
  localparam int S_FL = 18;

  // Operating modes
  localparam logic [2:0] MODE_STBY = 3'h0;
  localparam logic [2:0] MODE_DISCH = 3'h1;
  localparam logic [2:0] MODE_PRECHG = 3'h2;
  localparam logic [2:0] MODE_CHG = 3'h3;
  localparam logic [2:0] MODE_TORCH = 3'h4;
  localparam logic [2:0] MODE_PWM = 3'h5;
  localparam logic [2:0] MODE_STROBE = 3'h6;
  localparam logic [2:0] MODE_FLASH = 3'h7;
  localparam logic [1:0] TXM_MASK = 2'h1;
  localparam logic [1:0] TXM_TORCH = 2'h2;
  localparam logic [1:0] RNG_STD = 2'h0;
  localparam logic [1:0] RNG_LOW = 2'h1;
  localparam logic [1:0] RNG_HIGH = 2'h2;
  localparam logic [1:0] RNG_MAX = 2'h3;
  localparam logic [4:0] DUTY_1_32 = 5'h11;
  localparam logic [4:0] DUTY_3_32 = 5'h12;
  localparam logic [4:0] ENV_FULL = 5'h10;

  // Currents in 10 uA units
  localparam logic [16:0] LIM_TORCH = 17'h0B3B0;
  localparam logic [16:0] LIM_PWM = 17'h076B6;
  localparam logic [16:0] LIM_STROBE = 17'h16BAC;
  localparam logic [16:0] LIM_NONE = 17'h1FFFF;
  localparam logic [16:0] SHORT_MIN_STD = 17'h00B7C;
  localparam logic [16:0] SHORT_MIN_LOW = 17'h0080A;
  localparam logic [16:0] SHORT_MIN_HIGH = 17'h00931;
  localparam logic [16:0] RAMP_STEP = 17'h00064;

  // Pin order and status flag bits
  localparam int NPIN = 6;
  localparam int PIN_TRIG = 0;
  localparam int PIN_TXM = 1;
  localparam int PIN_CHG = 2;
  localparam int PIN_CONV = 3;
  localparam int PIN_VLOW = 4;
  localparam int PIN_OPEN = 5;
  localparam int ST_CHG = 0;
  localparam int ST_CONV = 1;
  localparam int ST_SHORT = 2;
  localparam int ST_OPEN = 3;
  localparam int ST_TMO = 4;
  localparam int ST_FDONE = 5;

  typedef enum logic [1:0] {FL_IDLE, FL_WAIT, FL_ON} flm_flash_t;
endpackage

// ---- flm_tick_div.sv ----
`timescale 1ns/1ps
module flm_tick_div #(
  parameter int DIV = 40
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  output logic tick_o
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_q, cnt_d;
  logic tick_q, tick_d;

  // Free running count, one pulse per wrap
  always_comb
  begin
    tick_d = (cnt_q == LAST);
    cnt_d = tick_d ? '0 : cnt_q + 1'b1;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;
endmodule // flm_tick_div

// ---- flm_led_ctrl.sv ----
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Functional notes
// RULE_01: TX mask input cuts boost 1 peak in flash
// RULE_02: Indicator enable bit switches indicator source on
// RULE_03: Zero blink field gives steady indicator
// RULE_04: Otherwise run the shaped blink sequence
// RULE_05: Indicator soft edges made by PWM
// RULE_06: LED current ramps at start and stop, but a fault or kill zeroes it at once
// RULE_07: No trigger: flash starts at write, timer ends
// RULE_08: Trigger type 0: rising edge starts timed flash
// RULE_09: Trigger type 1: pin level, cut by timeout
// RULE_10: Strobe torch drives only while trigger high
// RULE_11: Per mode current clamps, high range flash only
// RULE_12: PWM mode duty sixteenths or 1/32, 3/32
// RULE_13: Charge complete sets charge-done flag
// RULE_14: Conversion complete sets conversion-done flag
// RULE_15: Short check armed above range minimum current
// RULE_16: Low output voltage when armed means short
// RULE_17: LED fault flags, kills drive, forces discharge
// RULE_18: Timeout flag only for pin-defined flash
// RULE_19: Flash end loads post-flash mode
// RULE_20: Reading status clears only the flags it returned
// RULE_21: Duration counted by clocked timer from register
// RULE_22: Host configures everything before writing flash
module flm_led_ctrl #(
  parameter int MS_CYC = flm_pkg::MS_CYC_DEF
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic trig_i,
  input wire logic txmask_i,
  input wire logic charge_done_i,
  input wire logic conv_done_i,
  input wire logic led_vlow_i,
  input wire logic led_open_i,
  output logic [2:0] mode_o,
  output logic [16:0] led_drive_o,
  output logic led_en_o,
  output logic [1:0] led_range_o,
  output logic ind_en_o,
  output logic [3:0] ind_level_o,
  output logic [2:0] boost1_peak_limit_o,
  output logic boost1_off_o,
  output logic conv_off_o,
  output logic hold_cap_charged_o
);
  import flm_pkg::*;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  logic [NPIN-1:0] pin_w, s1_q, s2_q, s3_q, stab_q, stab_d, rise_w;
  logic us_tick, ms_tick, pwm_tick;
  logic apb_setup, apb_acc, apb_wr, addr_hit, rd_clr, ctrl_wr, fl_start;
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [LED_W-1:0] led_q, led_d;
  logic [FL_W-1:0] flash_q, flash_d;
  logic [IND_W-1:0] ind_q, ind_d;
  logic [BST_W-1:0] bst_q, bst_d;
  logic [31:0] prdata_q, prdata_d;
  logic kill_q, kill_d;
  logic [2:0] mode_w;
  logic trig_s, fault_evt, short_evt, open_evt;
  flm_flash_t fl_q, fl_d;
  logic [7:0] dur_q, dur_d, tmo_q, tmo_d;
  logic fl_end, tmo_evt;
  logic [16:0] drive_q, drive_d, tgt, lim, smin;
  logic act, gate, armed;
  logic [1:0] rng_w;
  logic [4:0] slot_q, slot_d, duty;
  logic pwm_hi;
  logic [11:0] ind_ms_q, ind_ms_d, per_len, on_len;
  logic [4:0] env_q, env_d;
  logic ind_on, ind_steady, ind_lit, ind_step;
  logic [7:0] flags_q, flags_d, flag_set;
  logic led_en_q, led_en_d, ind_en_q, ind_en_d, boff_q, boff_d;
  logic hold_q, hold_d;
  logic [1:0] rng_q;
  logic [2:0] peak_q, peak_d;

  // Pin synchronisers, a change accepted once stages two and three agree
  assign pin_w = {led_open_i, led_vlow_i, conv_done_i, charge_done_i,
                  txmask_i, trig_i};
  for (genvar g = 0; g < NPIN; g++)
  begin : g_sync
    assign stab_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : stab_q[g];
    assign rise_w[g] = stab_d[g] & ~stab_q[g];
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      stab_q <= '0;
    end
    else
    begin
      s1_q <= pin_w;
      s2_q <= s1_q;
      s3_q <= s2_q;
      stab_q <= stab_d;
    end
  end

  assign trig_s = stab_q[PIN_TRIG];

  // Timebases: 1 us ramp, 2 us PWM slot, 1 ms timers
  flm_tick_div #(.DIV(US_CYC)) u_us_div (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .tick_o(us_tick)
  );
  flm_tick_div #(.DIV(PWM_SLOT_CYC)) u_pwm_div (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .tick_o(pwm_tick)
  );
  flm_tick_div #(.DIV(MS_CYC)) u_ms_div (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .tick_o(ms_tick)
  );

  // APB decode, zero wait states, error on unmapped address
  assign apb_setup = psel_i & ~penable_i;
  assign apb_acc = psel_i & penable_i;
  assign addr_hit = paddr_i inside {ADDR_CTRL, ADDR_LED, ADDR_FLASH,
                    ADDR_IND, ADDR_BOOST, ADDR_STATUS, ADDR_STATE};
  assign apb_wr = apb_acc & pwrite_i & addr_hit;
  assign ctrl_wr = apb_wr & (paddr_i == ADDR_CTRL);
  assign fl_start = ctrl_wr & (pwdata_i[C_MODE+:3] == MODE_FLASH);
  assign rd_clr = apb_acc & ~pwrite_i & (paddr_i == ADDR_STATUS);
  assign pready_o = 1'b1;
  assign pslverr_o = apb_acc & ~addr_hit;
  assign prdata_o = prdata_q;
  assign mode_w = ctrl_q[C_MODE+:3];

  // Configuration registers and hardware mode overrides
  always_comb
  begin
    ctrl_d = ctrl_q;
    led_d = led_q;
    flash_d = flash_q;
    ind_d = ind_q;
    bst_d = bst_q;
    kill_d = kill_q;
    prdata_d = prdata_q;
    if (apb_wr)
    begin
      unique case (paddr_i)
        ADDR_CTRL: ctrl_d = pwdata_i[CTRL_W-1:0];
        ADDR_LED: led_d = pwdata_i[LED_W-1:0];
        ADDR_FLASH: flash_d = pwdata_i[FL_W-1:0];
        ADDR_IND: ind_d = pwdata_i[IND_W-1:0];
        ADDR_BOOST: bst_d = pwdata_i[BST_W-1:0];
        default: ;
      endcase
    end
    if (ctrl_wr)
      kill_d = 1'b0;
    if (fault_evt)
    begin
      ctrl_d[C_MODE+:3] = MODE_DISCH; // RULE_17
      kill_d = 1'b1; // RULE_17
    end
    else if (fl_end)
      ctrl_d[C_MODE+:3] = ctrl_q[C_POST+:3]; // RULE_19
    if (apb_setup && !pwrite_i)
    begin
      prdata_d = '0;
      unique case (paddr_i)
        ADDR_CTRL: prdata_d[CTRL_W-1:0] = ctrl_q;
        ADDR_LED: prdata_d[LED_W-1:0] = led_q;
        ADDR_FLASH: prdata_d[FL_W-1:0] = flash_q;
        ADDR_IND: prdata_d[IND_W-1:0] = ind_q;
        ADDR_BOOST: prdata_d[BST_W-1:0] = bst_q;
        ADDR_STATUS: prdata_d[7:0] = flags_q;
        ADDR_STATE:
        begin
          prdata_d[S_DRV+:17] = drive_q;
          prdata_d[S_EN] = led_en_q;
          prdata_d[S_FL+:2] = fl_q;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_q <= '0;
      led_q <= '0;
      flash_q <= '0;
      ind_q <= '0;
      bst_q <= '0;
      kill_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      led_q <= led_d;
      flash_q <= flash_d;
      ind_q <= ind_d;
      bst_q <= bst_d;
      kill_q <= kill_d;
      prdata_q <= prdata_d;
    end
  end

  // Flash sequencer with duration and timeout timers in ms
  always_comb
  begin
    fl_d = fl_q;
    dur_d = dur_q;
    tmo_d = tmo_q;
    fl_end = 1'b0;
    tmo_evt = 1'b0;
    if (fl_start)
    begin
      dur_d = flash_q[F_DUR+:8]; // RULE_21
      tmo_d = flash_q[F_TMO+:8];
      fl_d = pwdata_i[C_TEN] ? FL_WAIT : FL_ON; // RULE_07
    end
    else if (fault_evt || mode_w != MODE_FLASH)
      fl_d = FL_IDLE;
    else
    begin
      unique case (fl_q)
        FL_IDLE: ;
        FL_WAIT:
        begin
          if (ctrl_q[C_TTYPE] ? trig_s : rise_w[PIN_TRIG]) // RULE_08
          begin
            fl_d = FL_ON;
            dur_d = flash_q[F_DUR+:8]; // RULE_21
            tmo_d = flash_q[F_TMO+:8]; // RULE_18
          end
        end
        FL_ON:
        begin
          if (ms_tick && dur_q != '0)
            dur_d = dur_q - 8'h01; // RULE_21
          if (ms_tick && tmo_q != '0)
            tmo_d = tmo_q - 8'h01;
          if (ctrl_q[C_TEN] && ctrl_q[C_TTYPE])
          begin
            if (!trig_s)
              fl_end = 1'b1; // RULE_09
            else if (tmo_q == '0)
            begin
              fl_end = 1'b1; // RULE_09
              tmo_evt = 1'b1; // RULE_18
            end
          end
          else if (dur_q == '0)
            fl_end = 1'b1; // RULE_07
          if (fl_end)
            fl_d = FL_IDLE;
        end
        default: fl_d = FL_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fl_q <= FL_IDLE;
      dur_q <= '0;
      tmo_q <= '0;
    end
    else
    begin
      fl_q <= fl_d;
      dur_q <= dur_d;
      tmo_q <= tmo_d;
    end
  end

  // PWM slot counter and LED duty decode
  assign slot_d = pwm_tick ? slot_q + 5'h01 : slot_q;
  assign duty = led_q[L_DUTY+:5];
  always_comb
  begin
    if (duty == DUTY_1_32)
      pwm_hi = (slot_q == '0); // RULE_12
    else if (duty == DUTY_3_32)
      pwm_hi = (slot_q < 5'h03); // RULE_12
    else
      pwm_hi = ({1'b0, slot_q[3:0]} < duty); // RULE_12
  end

  // Mode dependent target, clamp, gating and short detection
  always_comb
  begin
    rng_w = led_q[L_RNG+:2];
    if ((mode_w != MODE_FLASH && rng_w == RNG_HIGH) || mode_w == MODE_PWM)
      rng_w = RNG_STD; // RULE_11
    act = 1'b0;
    gate = 1'b1;
    lim = LIM_NONE;
    unique case (mode_w)
      MODE_STBY, MODE_DISCH:
      begin
        act = (ctrl_q[C_TXM+:2] == TXM_TORCH) & stab_q[PIN_TXM];
        lim = LIM_TORCH; // RULE_11
      end
      MODE_PRECHG, MODE_CHG: ;
      MODE_TORCH:
      begin
        act = 1'b1;
        lim = LIM_TORCH; // RULE_11
      end
      MODE_PWM:
      begin
        act = 1'b1;
        lim = LIM_PWM; // RULE_11
        gate = pwm_hi; // RULE_12
      end
      MODE_STROBE:
      begin
        act = trig_s;
        lim = LIM_STROBE; // RULE_11
        gate = trig_s; // RULE_10
      end
      MODE_FLASH: act = (fl_q == FL_ON);
    endcase
    tgt = '0;
    if (act)
      tgt = (led_q[L_CUR+:17] > lim) ? lim : led_q[L_CUR+:17];
    unique case (rng_w)
      RNG_STD: smin = SHORT_MIN_STD; // RULE_15
      RNG_LOW: smin = SHORT_MIN_LOW;
      RNG_HIGH: smin = SHORT_MIN_HIGH;
      RNG_MAX: smin = LIM_NONE;
    endcase
    armed = (mode_w != MODE_PWM) && (rng_w != RNG_MAX) && (drive_q > smin);
    short_evt = armed & stab_q[PIN_VLOW]; // RULE_16
    open_evt = (mode_w != MODE_PWM) & (drive_q != '0) & stab_q[PIN_OPEN];
    fault_evt = short_evt | open_evt; // RULE_17
    drive_d = drive_q;
    if (fault_evt || kill_q)
      drive_d = '0; // RULE_17
    else if (us_tick && drive_q < tgt)
      drive_d = (tgt - drive_q > RAMP_STEP) ? drive_q + RAMP_STEP : tgt; // RULE_06
    else if (us_tick && drive_q > tgt)
      drive_d = (drive_q - tgt > RAMP_STEP) ? drive_q - RAMP_STEP : tgt; // RULE_06
  end

  // Indicator blink timing and PWM envelope
  assign ind_on = ind_q[I_ON];
  assign ind_steady = (ind_q[I_PER+:2] == '0) || (ind_q[I_ONT+:2] == '0);
  assign per_len = 12'(ind_q[I_PER+:2]) * BLINK_PER_UNIT_MS;
  assign on_len = 12'(ind_q[I_ONT+:2]) * BLINK_ON_UNIT_MS;
  assign ind_lit = ind_ms_q < on_len;
  assign ind_step = ms_tick && (ind_ms_q[IND_STEP_LOG2-1:0] == '0);
  always_comb
  begin
    ind_ms_d = ind_ms_q;
    env_d = env_q;
    if (!ind_on || ind_steady)
      ind_ms_d = '0;
    else if (ms_tick)
      ind_ms_d = (ind_ms_q >= per_len - 12'h001) ? '0 : ind_ms_q + 12'h001;
    if (!ind_on)
      env_d = '0; // RULE_02
    else if (ind_steady)
      env_d = ENV_FULL; // RULE_03
    else if (ind_lit)
    begin
      if (!ind_q[I_RISE])
        env_d = ENV_FULL; // RULE_04
      else if (ind_step && env_q < ENV_FULL)
        env_d = env_q + 5'h01; // RULE_05
    end
    else
    begin
      if (!ind_q[I_FALL])
        env_d = '0; // RULE_04
      else if (ind_step && env_q != '0)
        env_d = env_q - 5'h01; // RULE_05
    end
  end

  // Status flags, set wins over read clear
  always_comb
  begin
    flag_set = '0;
    flag_set[ST_CHG] = rise_w[PIN_CHG]; // RULE_13
    flag_set[ST_CONV] = rise_w[PIN_CONV]; // RULE_14
    flag_set[ST_SHORT] = short_evt; // RULE_16
    flag_set[ST_OPEN] = open_evt; // RULE_17
    flag_set[ST_TMO] = tmo_evt; // RULE_18
    flag_set[ST_FDONE] = fl_end;
    // Clear only the flags the setup cycle captured, so none is lost
    flags_d = (rd_clr ? (flags_q & ~prdata_q[7:0]) : flags_q)
              | flag_set; // RULE_20
  end

  // Registered drive outputs, boost limit with TX masking
  always_comb
  begin
    led_en_d = gate && (drive_d != '0) && !fault_evt;
    ind_en_d = ind_on && (env_q > {1'b0, slot_q[3:0]}); // RULE_05
    hold_d = ctrl_q[C_HOLD] && (mode_w == MODE_TORCH);
    peak_d = bst_q[B_PEAK+:3];
    boff_d = 1'b0;
    if (mode_w == MODE_FLASH && fl_q == FL_ON && stab_q[PIN_TXM]
        && ctrl_q[C_TXM+:2] == TXM_MASK)
    begin
      if (bst_q[B_RED+:3] > bst_q[B_PEAK+:3])
      begin
        peak_d = '0; // RULE_01
        boff_d = 1'b1;
      end
      else
        peak_d = bst_q[B_PEAK+:3] - bst_q[B_RED+:3]; // RULE_01
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      slot_q <= '0;
      drive_q <= '0;
      ind_ms_q <= '0;
      env_q <= '0;
      flags_q <= '0;
      led_en_q <= 1'b0;
      ind_en_q <= 1'b0;
      hold_q <= 1'b0;
      rng_q <= RNG_STD;
      peak_q <= '0;
      boff_q <= 1'b0;
    end
    else
    begin
      slot_q <= slot_d;
      drive_q <= drive_d;
      ind_ms_q <= ind_ms_d;
      env_q <= env_d;
      flags_q <= flags_d;
      led_en_q <= led_en_d;
      ind_en_q <= ind_en_d;
      hold_q <= hold_d;
      rng_q <= rng_w;
      peak_q <= peak_d;
      boff_q <= boff_d;
    end
  end

  assign mode_o = mode_w;
  assign led_drive_o = drive_q;
  assign led_en_o = led_en_q;
  assign led_range_o = rng_q;
  assign ind_en_o = ind_en_q;
  assign ind_level_o = ind_q[I_LVL+:4];
  assign boost1_peak_limit_o = peak_q;
  assign boost1_off_o = boff_q;
  assign conv_off_o = kill_q;
  assign hold_cap_charged_o = hold_q;

  // Checks
  sequence s_sw_flash;
    fl_start && !pwdata_i[C_TEN];
  endsequence
  sequence s_pin_flash_over;
    fl_q == FL_ON && ctrl_q[C_TEN] && ctrl_q[C_TTYPE] && trig_s
      && tmo_q == '0 && !fault_evt && !fl_start;
  endsequence

  a_ind_off: // RULE_02
  assert property (!ind_on |=> !ind_en_o)
    else $error("indicator on while disabled");
  a_ind_steady: // RULE_03
  assert property ((ind_on && ind_steady) [*3] |-> ind_en_o)
    else $error("steady indicator not lit");
  a_sw_flash: // RULE_07
  assert property (s_sw_flash |=> fl_q == FL_ON)
    else $error("flash did not start at write");
  a_edge_start: // RULE_08
  assert property (fl_q == FL_WAIT && !ctrl_q[C_TTYPE] && rise_w[PIN_TRIG]
                   && mode_w == MODE_FLASH && !fl_start && !fault_evt
                   |=> fl_q == FL_ON)
    else $error("trigger edge missed");
  a_timeout_cut: // RULE_09
  assert property (s_pin_flash_over |=> fl_q == FL_IDLE && flags_q[ST_TMO])
    else $error("timeout did not end flash");
  a_strobe_gate: // RULE_10
  assert property (mode_w == MODE_STROBE && !trig_s |=> !led_en_o)
    else $error("strobe torch driven with trigger low");
  a_torch_clamp: // RULE_11
  assert property ((mode_w == MODE_TORCH) [*2] |-> drive_q <= LIM_TORCH
                   || $past(drive_q) > drive_q)
    else $error("torch current above clamp");
  a_ramp_step: // RULE_06
  assert property (!kill_q && !fault_evt |=>
    ((drive_q >= $past(drive_q)) ? (drive_q - $past(drive_q))
     : ($past(drive_q) - drive_q)) <= RAMP_STEP)
    else $error("drive changed faster than ramp");
  a_short_fault: // RULE_17
  assert property (short_evt |=> mode_w == MODE_DISCH && flags_q[ST_SHORT]
                   ##1 drive_q == '0)
    else $error("short did not force discharge");
  a_post_mode: // RULE_19
  assert property (fl_end && !fault_evt |=> mode_w == $past(ctrl_q[C_POST+:3]))
    else $error("post flash mode not applied");
  a_read_clear: // RULE_20
  assert property (rd_clr && flag_set == '0
                   |=> (flags_q & $past(prdata_q[7:0])) == '0)
    else $error("status read did not clear flags");
  a_txm_peak: // RULE_01
  assert property (fl_q == FL_ON && mode_w == MODE_FLASH && stab_q[PIN_TXM]
                   && ctrl_q[C_TXM+:2] == TXM_MASK
                   && bst_q[B_RED+:3] <= bst_q[B_PEAK+:3]
                   |=> boost1_peak_limit_o
                   == $past(bst_q[B_PEAK+:3] - bst_q[B_RED+:3]))
    else $error("boost peak not reduced under TX mask");
endmodule // flm_led_ctrl

// ---- flm_host_model.sv ----
`timescale 1ns/1ps
module flm_host_model (
  input wire logic sys_clk_i,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o,
  output logic trig_o
);
  // Idle bus and trigger pin low
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h00000000;
    trig_o = 1'b0;
  end

  // One APB transfer, held until pready seen
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge sys_clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge sys_clk_i);
    penable_o <= 1'b1;
    do
      @(posedge sys_clk_i);
    while (pready_i !== 1'b1);
    r = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask

  // Trigger pin level, changed after an edge
  task automatic set_trig(input logic v);
    @(posedge sys_clk_i);
    trig_o <= v;
  endtask
endmodule // flm_host_model

// ---- flash_led_mode_control_tb.sv ----
`timescale 1ns/1ps
module flash_led_mode_control_tb;
  import flm_pkg::*;
  logic sys_clk_i, arst_n_i, psel, penable, pwrite, pready, pslverr, trig;
  logic chg_done, conv_done, vlow, open_led, led_en, ind_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0] mode;
  logic [16:0] drive;
  logic [1:0] rng;
  logic [3:0] ind_lvl;
  logic conv_off, e;
  logic txm, boff, hold;
  logic [2:0] bpeak;
  int fails = 0;
  int num_checks = 0;

  // Clock, 25 ns period
  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  flm_host_model flm_host_model_inst (.sys_clk_i(sys_clk_i),
    .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .trig_o(trig));

  flm_led_ctrl #(.MS_CYC(40)) flm_led_ctrl_inst (.sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .trig_i(trig), .txmask_i(txm), .charge_done_i(chg_done),
    .conv_done_i(conv_done), .led_vlow_i(vlow), .led_open_i(open_led),
    .mode_o(mode), .led_drive_o(drive), .led_en_o(led_en),
    .led_range_o(rng), .ind_en_o(ind_en), .ind_level_o(ind_lvl),
    .boost1_peak_limit_o(bpeak), .boost1_off_o(boff),
    .conv_off_o(conv_off), .hold_cap_charged_o(hold));

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    flm_host_model_inst.xfer(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a);
    flm_host_model_inst.xfer(1'b0, a, 32'h00000000, r, e);
  endtask

  // Wait bounded for a mode, then compare
  task automatic wait_mode(input logic [2:0] m, input int n);
    for (int i = 0; i < n && mode !== m; i++)
      @(posedge sys_clk_i);
    chk({29'h0, mode}, {29'h0, m});
  endtask

  task automatic give_verdict;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Unmapped address errors; timed flash then post mode
  task automatic t_flash;
    rd(12'h0FC);
    chk({31'h0, e}, 32'h1);
    wr(ADDR_LED, 32'h000003E8);
    wr(ADDR_FLASH, 32'h00000002);
    wr(ADDR_CTRL, 32'h00000407);
    wait_mode(MODE_TORCH, 300);
    rd(ADDR_STATUS);
    chk({31'h0, r[ST_FDONE]}, 32'h1);
    chk({31'h0, r[ST_TMO]}, 32'h0);
    rd(ADDR_STATUS);
    chk(r, 32'h00000000);
  endtask

  // Pin level flash cut by timeout
  task automatic t_type1;
    wr(ADDR_FLASH, 32'h00000105);
    wr(ADDR_CTRL, 32'h00000018 | 32'h7);
    flm_host_model_inst.set_trig(1'b1);
    wait_mode(MODE_STBY, 300);
    rd(ADDR_STATUS);
    chk({31'h0, r[ST_TMO]}, 32'h1);
    flm_host_model_inst.set_trig(1'b0);
  endtask

  // Strobe torch follows the pin
  task automatic t_strobe;
    wr(ADDR_CTRL, {29'h0, MODE_STROBE});
    repeat (200) @(posedge sys_clk_i);
    chk({31'h0, led_en}, 32'h0);
    flm_host_model_inst.set_trig(1'b1);
    repeat (200) @(posedge sys_clk_i);
    chk({31'h0, led_en}, 32'h1);
    flm_host_model_inst.set_trig(1'b0);
    repeat (10) @(posedge sys_clk_i);
    chk({31'h0, led_en}, 32'h0);
  endtask

  // Torch clamp with high range, then a short
  task automatic t_clamp_short;
    wr(ADDR_LED, 32'h0005FFFF);
    wr(ADDR_CTRL, {29'h0, MODE_TORCH});
    for (int i = 0; i < 25000 && drive !== LIM_TORCH; i++)
      @(posedge sys_clk_i);
    chk({15'h0, drive}, {15'h0, LIM_TORCH});
    chk({30'h0, rng}, {30'h0, RNG_STD});
    vlow <= 1'b1;
    wait_mode(MODE_DISCH, 20);
    chk({30'h0, led_en, conv_off}, 32'h1);
    rd(ADDR_STATUS);
    chk({31'h0, r[ST_SHORT]}, 32'h1);
    vlow <= 1'b0;
  endtask

  // Status flags from pin edges; steady indicator
  task automatic t_flags_ind;
    chg_done <= 1'b1;
    conv_done <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    rd(ADDR_STATUS);
    chk(r & 32'h3, 32'h3);
    wr(ADDR_IND, 32'h00000281);
    repeat (50) @(posedge sys_clk_i);
    chk({27'h0, ind_en, ind_lvl}, 32'h15);
  endtask

  // Hold output in torch; TX mask cuts boost peak during flash
  task automatic t_txmask;
    wr(ADDR_BOOST, 32'h00000015);
    txm <= 1'b1;
    wr(ADDR_CTRL, 32'h00000084);
    repeat (2) @(posedge sys_clk_i);
    chk({31'h0, hold}, 32'h1);
    wr(ADDR_FLASH, 32'h00000003);
    wr(ADDR_CTRL, 32'h00000027);
    repeat (8) @(posedge sys_clk_i);
    chk({27'h0, hold, boff, bpeak}, 32'h3);
    wr(ADDR_BOOST, 32'h00000035);
    repeat (2) @(posedge sys_clk_i);
    chk({27'h0, hold, boff, bpeak}, 32'h8);
    wait_mode(MODE_STBY, 300);
    repeat (2) @(posedge sys_clk_i);
    chk({27'h0, hold, boff, bpeak}, 32'h5);
    txm <= 1'b0;
  endtask

  // PWM mode at half duty, low range forced back to 00
  task automatic t_pwm;
    int n = 0;
    wr(ADDR_LED, 32'h004203E8);
    wr(ADDR_CTRL, {29'h0, MODE_PWM});
    repeat (600) @(posedge sys_clk_i);
    for (int i = 0; i < 1280; i++)
    begin
      @(posedge sys_clk_i);
      n += led_en;
    end
    chk(n, 32'h00000280);
    chk({30'h0, rng}, {30'h0, RNG_STD});
  endtask

  // Watchdog
  initial
  begin
    #(25 * 90000);
    fails++;
    give_verdict;
  end

  initial
  begin
    arst_n_i = 1'b0;
    {txm, chg_done, conv_done, vlow, open_led} = 5'h00;
    repeat (20) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    t_flash;
    t_type1;
    t_strobe;
    t_clamp_short;
    t_flags_ind;
    t_txmask;
    t_pwm;
    give_verdict;
  end
endmodule // flash_led_mode_control_tb
